// ==== hdl/vc2tc_consts.svh ====
/*
 Constants of the tandem-connection monitor: frame geometry, multiframe
 positions, overhead bit positions, filters and counter widths.
 Assumes byte-wide VC-2 data with bit 1 of each byte in bit 7.
*/
`ifndef VC2TC_CONSTS_SVH
`define VC2TC_CONSTS_SVH
`define VC2TC_FRAME_BYTES 428
`define VC2TC_N2_POS 214
`define VC2TC_BIP_HI 7
`define VC2TC_BIP_LO 6
`define VC2TC_REI_BIT 3
`define VC2TC_OEI_BIT 2
`define VC2TC_MF_HI 1
`define VC2TC_MF_LO 0
`define VC2TC_MF_LEN 7'h4C
`define VC2TC_FAS_LAST 7'h07
`define VC2TC_TTI_FIRST 7'h08
`define VC2TC_TTI_LAST 7'h47
`define VC2TC_RDI_FRAME 7'h48
`define VC2TC_ODI_FRAME 7'h49
`define VC2TC_FAS_WORD 16'hFFFE
`define VC2TC_TRACE_BITS 128
`define VC2TC_ACCEPT 3
`define VC2TC_PERSIST 5
`define VC2TC_CNT_W 16
`endif

// ==== hdl/vc2tc_pkg.sv ====
/*
 Types shared by the tandem-connection monitor modules.
 Assumes nothing beyond the constants header.
*/
package vc2tc_pkg;
	typedef enum logic {out_of_multiframe, in_multiframe} vc2tc_mf_type;
endpackage

// ==== hdl/vc2tc_ev_if.sv ====
/*
 Event carrier between the overhead decoder and the performance counters.
 Assumes one clock; pulses last one clk_sys cycle.
*/
`timescale 1ns/10ps
`default_nettype none
interface vc2tc_ev_if;
	logic near_eb;
	logic far_eb;
	logic ofar_eb;
	logic trail_fail;
	logic remote_defect;
	logic outgoing_defect;
	logic degrade;
	modport src (output near_eb, far_eb, ofar_eb, trail_fail,
		remote_defect, outgoing_defect, input degrade);
	modport pm (input near_eb, far_eb, ofar_eb, trail_fail,
		remote_defect, outgoing_defect, output degrade);
endinterface
`default_nettype wire

// ==== hdl/vc2tc_persist.sv ====
/*
 Persistence filter: the state flips after LEN consecutive strobes
 whose level differs from it. Assumes strobes are one cycle long.
*/
`timescale 1ns/10ps
`default_nettype none
`include "vc2tc_consts.svh"
module vc2tc_persist
	import vc2tc_pkg::*;
#(
	parameter int unsigned LEN = `VC2TC_PERSIST
) (
	// Clock and reset
	input wire logic clk_sys,
	input wire logic rst_n,
	// Sample
	input wire logic stb,
	input wire logic level,
	// Filtered state
	output logic defect
);
	logic [3:0] cnt_q, cnt_d;
	logic state_q, state_d;

	if (LEN < 1 || LEN > 15) $error("LEN out of range");

	always_comb begin
		cnt_d = cnt_q;
		state_d = state_q;
		if (stb) begin
			if (level == state_q) begin
				cnt_d = '0;
			end else if (cnt_q == 4'(LEN - 1)) begin
				state_d = level;
				cnt_d = '0;
			end else begin
				cnt_d = cnt_q + 4'h1;
			end
		end
	end

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			cnt_q <= '0;
			state_q <= 1'h0;
		end else begin
			cnt_q <= cnt_d;
			state_q <= state_d;
		end
	end

	assign defect = state_q;

	default clocking @(posedge clk_sys); endclocking
	default disable iff (!rst_n);
	property p_flip;
		$changed(state_q) |-> $past(stb) && $past(cnt_q) == 4'(LEN - 1);
	endproperty
	a_flip: assert property (p_flip) else $error("early flip");
endmodule // vc2tc_persist
`default_nettype wire

// ==== hdl/vc2tc_pm.sv ====
/*
 Per-second performance counts, defect-second flags and degrade
 detection. Assumes one_second is a one-cycle pulse on clk_sys.
*/
`timescale 1ns/10ps
`default_nettype none
`include "vc2tc_consts.svh"
module vc2tc_pm
	import vc2tc_pkg::*;
#(
	parameter int unsigned CNT_W = `VC2TC_CNT_W
) (
	// Clock and reset
	input wire logic clk_sys,
	input wire logic rst_n,
	// Timing and degrade settings
	input wire logic one_second,
	input wire logic [3:0] degrade_window_count,
	input wire logic [CNT_W-1:0] degrade_threshold,
	// Events
	vc2tc_ev_if.pm ev,
	// Results
	output logic [CNT_W-1:0] near_error_count,
	output logic [CNT_W-1:0] far_error_count,
	output logic [CNT_W-1:0] outgoing_far_error_count,
	output logic near_defect_second,
	output logic far_defect_second,
	output logic outgoing_far_defect_second
);
	logic [CNT_W-1:0] acc_q [3], acc_d [3], cnt_q [3], cnt_d [3];
	logic [CNT_W-1:0] total [3];
	logic [CNT_W-1:0] near_total;
	logic [2:0] ev_vec, lvl_vec, dsa_q, dsa_d, ds_q, ds_d;
	logic [3:0] bad_q, bad_d, good_q, good_d;
	logic deg_q, deg_d, bad_sec;

	if (CNT_W < 12 || CNT_W > 32) $error("CNT_W out of range");

	assign ev_vec = {ev.ofar_eb, ev.far_eb, ev.near_eb};
	assign lvl_vec = {ev.outgoing_defect, ev.remote_defect, ev.trail_fail};
	assign near_total = total[0];
	assign bad_sec = (degrade_threshold != '0) &&
		(total[0] >= degrade_threshold);

	always_comb begin
		bad_d = bad_q;
		good_d = good_q;
		deg_d = deg_q;
		for (int i = 0; i < 3; i++) begin
			total[i] = (&acc_q[i]) ? acc_q[i] : acc_q[i] + CNT_W'(ev_vec[i]);
			acc_d[i] = one_second ? '0 : total[i];
			cnt_d[i] = one_second ? total[i] : cnt_q[i];
			dsa_d[i] = one_second ? 1'h0 : (dsa_q[i] | lvl_vec[i]);
			ds_d[i] = one_second ? (dsa_q[i] | lvl_vec[i]) : ds_q[i];
		end
		if (one_second) begin
			if (bad_sec) begin
				good_d = '0;
				bad_d = (bad_q == 4'hF) ? bad_q : bad_q + 4'h1;
				if (degrade_window_count != '0 &&
					bad_d >= degrade_window_count) begin
					deg_d = 1'h1;
				end
			end else begin
				bad_d = '0;
				good_d = (good_q == 4'hF) ? good_q : good_q + 4'h1;
				if (good_d >= degrade_window_count) begin
					deg_d = 1'h0;
				end
			end
		end
	end

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			for (int i = 0; i < 3; i++) begin
				acc_q[i] <= '0;
				cnt_q[i] <= '0;
			end
			dsa_q <= '0;
			ds_q <= '0;
			bad_q <= '0;
			good_q <= '0;
			deg_q <= 1'h0;
		end else begin
			acc_q <= acc_d;
			cnt_q <= cnt_d;
			dsa_q <= dsa_d;
			ds_q <= ds_d;
			bad_q <= bad_d;
			good_q <= good_d;
			deg_q <= deg_d;
		end
	end

	assign near_error_count = cnt_q[0];
	assign far_error_count = cnt_q[1];
	assign outgoing_far_error_count = cnt_q[2];
	assign near_defect_second = ds_q[0];
	assign far_defect_second = ds_q[1];
	assign outgoing_far_defect_second = ds_q[2];
	assign ev.degrade = deg_q;

	default clocking @(posedge clk_sys); endclocking
	default disable iff (!rst_n);
	property p_latch;
		one_second |=> near_error_count == $past(near_total) && acc_q[0] == '0;
	endproperty
	a_latch: assert property (p_latch) else $error("count not latched");
	property p_near_ds;
		ev.trail_fail && one_second |=> near_defect_second;
	endproperty
	a_near_ds: assert property (p_near_ds) else $error("ds flag lost");
endmodule // vc2tc_pm
`default_nettype wire

// ==== hdl/vc2tc_monitor.sv ====
/*
 Non-intrusive tandem-connection monitor for a VC-2 byte stream:
 parity check, multiframe alignment, trace recovery, remote and
 outgoing indications, defects, correlated reports and counts.
 Assumes data, valid and frame start come from logic on clk_sys and
 that the N2 byte sits at a fixed offset from the frame start.
*/
`timescale 1ns/10ps
`default_nettype none
`include "vc2tc_consts.svh"
// Function
// - Even BIP-2 over previous frame compared with recovered bits 1-2.
// - A parity difference flags one near-end errored block.
// - Recover the trail trace and expose the accepted value.
// - Only the first trace mode is supported.
// - Bit 4 of the overhead byte is ignored.
// - Extract remote error bit and multiframed remote defect bit.
// - Remote defect one means defect, zero means normal.
// - Extract outgoing error bit and multiframed outgoing defect bit.
// - Outgoing defect one means defect, zero means normal.
// - Search bits 7-8 for the sixteen-bit alignment word, keep checking.
// - Two consecutive errored alignment words give out-of-multiframe.
// - One error-free alignment word gives in-multiframe.
// - Unequipped after five zero bytes, cleared after five non-zero.
// - Tandem loss follows out-of-multiframe state.
// - Trace mismatch detected and cleared within one second.
// - Mismatch suppressed under server fail, disabled by management.
// - Degrade defect from counted parity violations.
// - Trail fail is OR of four faults; trail degrade follows degrade.
// - Unequipped first, then tandem loss, then trace mismatch reported.
// - Degrade reported without mismatch or loss; server fail if enabled.
// - Remote/outgoing reported only if enabled and no connectivity fault.
// - Per-second defect-second flags and error counts, three ends.
module vc2tc_monitor
	import vc2tc_pkg::*;
#(
	parameter int unsigned FRAME_BYTES = `VC2TC_FRAME_BYTES,
	parameter int unsigned N2_POS = `VC2TC_N2_POS,
	parameter int unsigned CNT_W = `VC2TC_CNT_W
) (
	// Clock and reset
	input wire logic clk_sys,
	input wire logic rst_n,
	// Incoming stream
	input wire logic [7:0] vc_data,
	input wire logic vc_valid,
	input wire logic vc_frame_start,
	input wire logic server_fail,
	// Management controls
	input wire logic [`VC2TC_TRACE_BITS-1:0] expected_trace,
	input wire logic mismatch_disable,
	input wire logic termination_point_mode,
	input wire logic server_fail_report_en,
	input wire logic remote_defect_report_en,
	input wire logic outgoing_defect_report_en,
	input wire logic [3:0] degrade_window_count,
	input wire logic [CNT_W-1:0] degrade_threshold,
	input wire logic one_second,
	// Consequent actions
	output logic trail_fail_action,
	output logic trail_degrade_action,
	// Fault reports
	output logic unequipped_report,
	output logic tandem_loss_report,
	output logic trace_mismatch_report,
	output logic degrade_report,
	output logic server_fail_report,
	output logic remote_defect_report,
	output logic outgoing_defect_report,
	// Trace
	output logic [`VC2TC_TRACE_BITS-1:0] accepted_trace,
	// Per-second performance
	output logic [CNT_W-1:0] near_error_count,
	output logic [CNT_W-1:0] far_error_count,
	output logic [CNT_W-1:0] outgoing_far_error_count,
	output logic near_defect_second,
	output logic far_defect_second,
	output logic outgoing_far_defect_second
);
	localparam int unsigned TB = `VC2TC_TRACE_BITS;

	if (FRAME_BYTES > 512 || N2_POS >= FRAME_BYTES || CNT_W < 12)
		$error("frame geometry or count width out of range");

	function automatic logic [1:0] bip_pairs(input logic [7:0] b);
		return {b[7] ^ b[5] ^ b[3] ^ b[1], b[6] ^ b[4] ^ b[2] ^ b[0]};
	endfunction

	vc2tc_ev_if ev_bus ();

	// ----------------------------------------------------------------
	// Frame counting and parity
	// ----------------------------------------------------------------
	logic [8:0] byte_cnt_q, byte_cnt_d, byte_idx;
	logic [1:0] acc_q, acc_d, prev_q, prev_d, rx_bip;
	logic seen_q, seen_d, prev_ok_q, prev_ok_d, n2_here;
	logic n2_stb_q, n2_stb_d, bip_err_q, bip_err_d;
	logic [7:0] n2_q, n2_d;

	assign byte_idx = vc_frame_start ? '0 : byte_cnt_q;
	assign n2_here = vc_valid && byte_idx == 9'(N2_POS);
	assign rx_bip = vc_data[`VC2TC_BIP_HI:`VC2TC_BIP_LO];

	always_comb begin
		byte_cnt_d = byte_cnt_q;
		acc_d = acc_q;
		prev_d = prev_q;
		seen_d = seen_q;
		prev_ok_d = prev_ok_q;
		n2_stb_d = 1'h0;
		n2_d = n2_q;
		bip_err_d = bip_err_q;
		if (vc_valid) begin
			byte_cnt_d = (byte_idx == 9'(FRAME_BYTES - 1)) ? '0 :
				byte_idx + 9'h001;
			if (vc_frame_start) begin
				acc_d = bip_pairs(vc_data);
				prev_d = acc_q;
				seen_d = 1'h1;
				prev_ok_d = seen_q;
			end else begin
				acc_d = acc_q ^ bip_pairs(vc_data);
			end
			if (n2_here) begin
				n2_stb_d = 1'h1;
				n2_d = vc_data;
				bip_err_d = prev_ok_q && rx_bip != prev_q;
			end
		end
	end

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			byte_cnt_q <= '0;
			acc_q <= '0;
			prev_q <= '0;
			seen_q <= 1'h0;
			prev_ok_q <= 1'h0;
			n2_stb_q <= 1'h0;
			n2_q <= '0;
			bip_err_q <= 1'h0;
		end else begin
			byte_cnt_q <= byte_cnt_d;
			acc_q <= acc_d;
			prev_q <= prev_d;
			seen_q <= seen_d;
			prev_ok_q <= prev_ok_d;
			n2_stb_q <= n2_stb_d;
			n2_q <= n2_d;
			bip_err_q <= bip_err_d;
		end
	end

	// ----------------------------------------------------------------
	// Multiframe alignment, trace and remote indications
	// ----------------------------------------------------------------
	vc2tc_mf_type mf_state_q, mf_state_d;
	logic [6:0] mf_idx_q, mf_idx_d;
	logic [15:0] fas_q, fas_d, fas_next;
	logic fas_bad_q, fas_bad_d;
	logic [TB-1:0] tsr_q, tsr_d, tnext, rx_trace_q, rx_trace_d;
	logic [TB-1:0] acc_trace_q, acc_trace_d;
	logic [1:0] match_q, match_d;
	logic rdi_stb_q, rdi_stb_d, odi_stb_q, odi_stb_d, ind_q, ind_d;
	logic tandem_loss_defect;

	assign fas_next = {fas_q[13:0], n2_q[`VC2TC_MF_HI:`VC2TC_MF_LO]};
	assign tnext = {tsr_q[TB-3:0], n2_q[`VC2TC_MF_HI:`VC2TC_MF_LO]};

	always_comb begin
		mf_state_d = mf_state_q;
		mf_idx_d = mf_idx_q;
		fas_d = fas_q;
		fas_bad_d = fas_bad_q;
		tsr_d = tsr_q;
		rx_trace_d = rx_trace_q;
		acc_trace_d = acc_trace_q;
		match_d = match_q;
		rdi_stb_d = 1'h0;
		odi_stb_d = 1'h0;
		ind_d = ind_q;
		if (n2_stb_q) begin
			fas_d = fas_next;
			case (mf_state_q)
				out_of_multiframe: begin
					if (fas_next == `VC2TC_FAS_WORD) begin
						mf_state_d = in_multiframe;
						mf_idx_d = `VC2TC_TTI_FIRST;
						fas_bad_d = 1'h0;
					end
				end
				in_multiframe: begin
					mf_idx_d = (mf_idx_q == `VC2TC_MF_LEN - 7'h01) ? '0 :
						mf_idx_q + 7'h01;
					if (mf_idx_q == `VC2TC_FAS_LAST) begin
						fas_bad_d = fas_next != `VC2TC_FAS_WORD;
						if (fas_bad_d && fas_bad_q) begin
							mf_state_d = out_of_multiframe;
						end
					end
					if (mf_idx_q >= `VC2TC_TTI_FIRST &&
						mf_idx_q <= `VC2TC_TTI_LAST) begin
						tsr_d = tnext;
					end
					if (mf_idx_q == `VC2TC_TTI_LAST) begin
						if (tnext == rx_trace_q) begin
							if (match_q != 2'(`VC2TC_ACCEPT - 1)) begin
								match_d = match_q + 2'h1;
							end
							if (match_q >= 2'(`VC2TC_ACCEPT - 2)) begin
								acc_trace_d = rx_trace_q;
							end
						end else begin
							rx_trace_d = tnext;
							match_d = '0;
						end
					end
					if (mf_idx_q == `VC2TC_RDI_FRAME) begin
						rdi_stb_d = 1'h1;
						ind_d = n2_q[`VC2TC_MF_LO];
					end
					if (mf_idx_q == `VC2TC_ODI_FRAME) begin
						odi_stb_d = 1'h1;
						ind_d = n2_q[`VC2TC_MF_HI];
					end
				end
				default: mf_state_d = out_of_multiframe;
			endcase
		end
	end

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			mf_state_q <= out_of_multiframe;
			mf_idx_q <= '0;
			fas_q <= '0;
			fas_bad_q <= 1'h0;
			tsr_q <= '0;
			rx_trace_q <= '0;
			acc_trace_q <= '0;
			match_q <= '0;
			rdi_stb_q <= 1'h0;
			odi_stb_q <= 1'h0;
			ind_q <= 1'h0;
		end else begin
			mf_state_q <= mf_state_d;
			mf_idx_q <= mf_idx_d;
			fas_q <= fas_d;
			fas_bad_q <= fas_bad_d;
			tsr_q <= tsr_d;
			rx_trace_q <= rx_trace_d;
			acc_trace_q <= acc_trace_d;
			match_q <= match_d;
			rdi_stb_q <= rdi_stb_d;
			odi_stb_q <= odi_stb_d;
			ind_q <= ind_d;
		end
	end

	assign tandem_loss_defect = mf_state_q == out_of_multiframe;
	assign accepted_trace = acc_trace_q;

	// ----------------------------------------------------------------
	// Persistence filters
	// ----------------------------------------------------------------
	logic unequipped_defect, remote_defect, outgoing_defect;

	vc2tc_persist #(.LEN(`VC2TC_PERSIST)) u_uneq (
		.clk_sys(clk_sys),
		.rst_n(rst_n),
		.stb(n2_stb_q),
		.level(n2_q == 8'h00),
		.defect(unequipped_defect)
	);
	vc2tc_persist #(.LEN(`VC2TC_PERSIST)) u_rdi (
		.clk_sys(clk_sys),
		.rst_n(rst_n),
		.stb(rdi_stb_q),
		.level(ind_q),
		.defect(remote_defect)
	);
	vc2tc_persist #(.LEN(`VC2TC_PERSIST)) u_odi (
		.clk_sys(clk_sys),
		.rst_n(rst_n),
		.stb(odi_stb_q),
		.level(ind_q),
		.defect(outgoing_defect)
	);

	// ----------------------------------------------------------------
	// Defects, actions and correlated reports
	// ----------------------------------------------------------------
	logic tim_q, tim_d, tsf_q, tsf_d, tsd_q, tsd_d;
	logic [6:0] rep_q, rep_d;
	logic trace_mismatch_defect, degrade_defect, monitoring_active, conn;

	assign trace_mismatch_defect = tim_q;
	assign degrade_defect = ev_bus.degrade;
	assign monitoring_active = termination_point_mode;
	assign conn = unequipped_defect | tim_q | tandem_loss_defect;

	always_comb begin
		tim_d = !mismatch_disable && !server_fail &&
			acc_trace_q != expected_trace;
		tsf_d = server_fail | conn;
		tsd_d = degrade_defect;
		rep_d[0] = monitoring_active & unequipped_defect;
		rep_d[1] = monitoring_active & !unequipped_defect &
			tandem_loss_defect;
		rep_d[2] = monitoring_active & !unequipped_defect &
			!tandem_loss_defect & tim_q;
		rep_d[3] = monitoring_active & !tim_q & !tandem_loss_defect &
			degrade_defect;
		rep_d[4] = monitoring_active & server_fail &
			server_fail_report_en;
		rep_d[5] = monitoring_active & !conn & remote_defect &
			remote_defect_report_en;
		rep_d[6] = monitoring_active & !conn & outgoing_defect &
			outgoing_defect_report_en;
	end

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			tim_q <= 1'h0;
			tsf_q <= 1'h0;
			tsd_q <= 1'h0;
			rep_q <= '0;
		end else begin
			tim_q <= tim_d;
			tsf_q <= tsf_d;
			tsd_q <= tsd_d;
			rep_q <= rep_d;
		end
	end

	assign trail_fail_action = tsf_q;
	assign trail_degrade_action = tsd_q;
	assign unequipped_report = rep_q[0];
	assign tandem_loss_report = rep_q[1];
	assign trace_mismatch_report = rep_q[2];
	assign degrade_report = rep_q[3];
	assign server_fail_report = rep_q[4];
	assign remote_defect_report = rep_q[5];
	assign outgoing_defect_report = rep_q[6];

	// ----------------------------------------------------------------
	// Performance monitoring
	// ----------------------------------------------------------------
	assign ev_bus.near_eb = n2_stb_q & bip_err_q;
	assign ev_bus.far_eb = n2_stb_q & n2_q[`VC2TC_REI_BIT];
	assign ev_bus.ofar_eb = n2_stb_q & n2_q[`VC2TC_OEI_BIT];
	assign ev_bus.trail_fail = tsf_q;
	assign ev_bus.remote_defect = remote_defect;
	assign ev_bus.outgoing_defect = outgoing_defect;

	vc2tc_pm #(.CNT_W(CNT_W)) u_pm (
		.clk_sys(clk_sys),
		.rst_n(rst_n),
		.one_second(one_second),
		.degrade_window_count(degrade_window_count),
		.degrade_threshold(degrade_threshold),
		.ev(ev_bus),
		.near_error_count(near_error_count),
		.far_error_count(far_error_count),
		.outgoing_far_error_count(outgoing_far_error_count),
		.near_defect_second(near_defect_second),
		.far_defect_second(far_defect_second),
		.outgoing_far_defect_second(outgoing_far_defect_second)
	);

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	default clocking @(posedge clk_sys); endclocking
	default disable iff (!rst_n);
	property p_bip;
		n2_here && prev_ok_q |=>
			ev_bus.near_eb == ($past(rx_bip) != $past(prev_q));
	endproperty
	a_bip: assert property (p_bip) else $error("parity flag wrong");
	property p_loss;
		n2_stb_q && mf_state_q == in_multiframe &&
		mf_idx_q == `VC2TC_FAS_LAST && fas_bad_q &&
		fas_next != `VC2TC_FAS_WORD |=> tandem_loss_defect;
	endproperty
	a_loss: assert property (p_loss) else $error("loss missed");
	property p_regain;
		n2_stb_q && tandem_loss_defect && fas_next == `VC2TC_FAS_WORD
		|=> !tandem_loss_defect && mf_idx_q == `VC2TC_TTI_FIRST;
	endproperty
	a_regain: assert property (p_regain) else $error("no regain");
	property p_ltc_rep;
		tandem_loss_report |-> $past(tandem_loss_defect) &&
			$past(monitoring_active) && !$past(unequipped_defect);
	endproperty
	a_ltc_rep: assert property (p_ltc_rep) else $error("bad loss rep");
	property p_tim_off;
		server_fail || mismatch_disable |=> !trace_mismatch_defect;
	endproperty
	a_tim_off: assert property (p_tim_off) else $error("tim shown");
	property p_tsf;
		rst_n && (server_fail || tandem_loss_defect || unequipped_defect)
		|=> trail_fail_action;
	endproperty
	a_tsf: assert property (p_tsf) else $error("trail fail missing");
	property p_rdi_rep;
		remote_defect_report |-> $past(remote_defect) &&
			$past(remote_defect_report_en) && !$past(tim_q) &&
			!$past(tandem_loss_defect);
	endproperty
	a_rdi_rep: assert property (p_rdi_rep) else $error("bad rdi rep");
	property p_trace;
		$changed(acc_trace_q) |-> $past(n2_stb_q) &&
			$past(mf_idx_q) == `VC2TC_TTI_LAST;
	endproperty
	a_trace: assert property (p_trace) else $error("trace timing");
endmodule // vc2tc_monitor
`default_nettype wire

// ==== verification/vc2tc_src.sv ====
/*
 Upstream VC-2 source model: frames, BIP-2 and multiframed N2 bits.
 Assumes the bench drives its controls from clk_sys.
*/
`timescale 1ns/10ps
`default_nettype none
module vc2tc_src
	import vc2tc_pkg::*;
#(
	parameter int unsigned FB = 32,
	parameter int unsigned N2P = 16
) (
	// Clock and reset
	input wire logic clk_sys,
	input wire logic rst_n,
	// Controls
	input wire logic [7:0] pay,
	input wire logic err,
	input wire logic rei,
	input wire logic oei,
	input wire logic zero,
	input wire logic fas_bad,
	input wire logic rdi,
	input wire logic odi,
	input wire logic [127:0] trace,
	// Stream
	output logic [7:0] vc_data,
	output logic vc_valid,
	output logic vc_frame_start
);
	logic [8:0] idx;
	logic [6:0] mf;
	logic [1:0] acc;
	logic [1:0] prev;
	logic [1:0] mfb;
	logic [7:0] b;
	function automatic logic [1:0] pr(input logic [7:0] d);
		return {d[7] ^ d[5] ^ d[3] ^ d[1], d[6] ^ d[4] ^ d[2] ^ d[0]};
	endfunction
	always_comb begin
		mfb = 2'h0;
		if (mf < 7'h08)
			mfb = (mf == 7'h07 && !fas_bad) ? 2'h2 : 2'h3;
		else if (mf < 7'h48)
			mfb = trace[127 - 2 * (int'(mf) - 8) -: 2];
		else if (mf == 7'h48)
			mfb = {1'b0, rdi};
		else if (mf == 7'h49)
			mfb = {odi, 1'b0};
		b = pay;
		// Random bit 4
		if (idx == N2P)
			b = {prev ^ {2{err}}, 1'b1, pay[4], rei, oei, mfb};
		if (idx == N2P && zero)
			b = 8'h00;
	end
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			idx <= 9'h000;
			mf <= 7'h00;
			acc <= 2'h0;
			prev <= 2'h0;
			vc_data <= 8'h00;
			vc_valid <= 1'b0;
			vc_frame_start <= 1'b0;
		end else begin
			vc_data <= b;
			vc_valid <= 1'b1;
			vc_frame_start <= (idx == 9'h000);
			idx <= (idx == FB - 1) ? 9'h000 : idx + 9'h001;
			acc <= (idx == 9'h000) ? pr(b) : acc ^ pr(b);
			if (idx == FB - 1) begin
				prev <= acc ^ pr(b);
				mf <= (mf == 7'h4B) ? 7'h00 : mf + 7'h01;
			end
		end
	end
endmodule // vc2tc_src
`default_nettype wire

// ==== verification/tb_vc2_tandem_conn_monitor_sink.sv ====
/*
 Self-checking bench of the tandem-connection monitor.
 Assumes the source model and short 32-byte frames.
*/
`timescale 1ns/10ps
`default_nettype none
module tb_vc2_tandem_conn_monitor_sink
	import vc2tc_pkg::*;
;
	logic clk_sys = 1'b0;
	logic rst_n = 1'b0;
	logic [31:0] rng = 32'hF63B;
	logic [7:0] pay = 8'h00;
	logic err = 1'b0, rei = 1'b0, oei = 1'b0, zero = 1'b0, fas_bad = 1'b0;
	logic rdi = 1'b1, odi = 1'b1, server_fail = 1'b0;
	logic mismatch_disable = 1'b0, termination_point_mode = 1'b1;
	logic one_second = 1'b0, ssf_en = 1'b1, en = 1'b1;
	logic [127:0] trace, expected_trace, accepted_trace;
	logic [7:0] vc_data;
	logic vc_valid, vc_frame_start, trail_fail_action, trail_degrade_action;
	logic unequipped_report, tandem_loss_report, trace_mismatch_report;
	logic degrade_report, server_fail_report, remote_defect_report;
	logic outgoing_defect_report, near_defect_second, far_defect_second;
	logic outgoing_far_defect_second;
	logic [15:0] near_error_count, far_error_count, outgoing_far_error_count;
	int errors = 0;
	int check_count = 0;
	always #20 clk_sys = ~clk_sys;
	function automatic logic [31:0] xs();
		rng ^= rng << 13;
		rng ^= rng >> 17;
		rng ^= rng << 5;
		return rng;
	endfunction
	function automatic logic tsf(input logic s, u, t, l);
		return s | u | t | l;
	endfunction
	always @(posedge clk_sys) pay <= 8'(xs());
	vc2tc_src #(.FB(32), .N2P(16)) u_src (.clk_sys, .rst_n, .pay, .err,
		.rei, .oei, .zero, .fas_bad, .rdi, .odi, .trace, .vc_data,
		.vc_valid, .vc_frame_start);
	vc2tc_monitor #(.FRAME_BYTES(32), .N2_POS(16)) DUT (.clk_sys, .rst_n,
		.vc_data, .vc_valid, .vc_frame_start, .server_fail, .expected_trace,
		.mismatch_disable, .termination_point_mode,
		.server_fail_report_en(ssf_en), .remote_defect_report_en(en),
		.outgoing_defect_report_en(en), .degrade_window_count(4'h1),
		.degrade_threshold(16'h0001), .one_second, .trail_fail_action,
		.trail_degrade_action, .unequipped_report, .tandem_loss_report,
		.trace_mismatch_report, .degrade_report, .server_fail_report,
		.remote_defect_report, .outgoing_defect_report, .accepted_trace,
		.near_error_count, .far_error_count, .outgoing_far_error_count,
		.near_defect_second, .far_defect_second, .outgoing_far_defect_second);
	task chk(input logic [127:0] seen, input logic [127:0] exp);
		check_count++;
		if (seen !== exp) begin
			errors++;
			$display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task summarize();
		$display("checks=%0d errors=%0d", check_count, errors);
		if (errors == 0 && check_count > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	task frames(input int n);
		repeat (n) begin
			@(posedge clk_sys);
			one_second <= 1'b0;
			while (vc_frame_start !== 1'b1) @(posedge clk_sys);
		end
	endtask
	initial begin
		#1600000;
		errors++;
		summarize();
	end
	initial begin
		int ne, nf, nof;
		logic e, r, o;
		trace = {xs(), xs(), xs(), xs()} & {16{8'h3F}};
		expected_trace = trace;
		repeat (12) @(posedge clk_sys);
		rst_n <= 1'b1;
		frames(1);
		chk(tandem_loss_report, 1'b1);
		chk(trace_mismatch_report, 1'b0);
		chk(trail_fail_action, tsf(1'b0, 1'b0, 1'b1, 1'b1));
		frames(456);
		chk(tandem_loss_report, 1'b0);
		chk(accepted_trace, trace);
		chk(trace_mismatch_report, 1'b0);
		chk(trail_fail_action, tsf(1'b0, 1'b0, 1'b0, 1'b0));
		chk(remote_defect_report, rdi);
		chk(outgoing_defect_report, odi);
		en <= 1'b0;
		frames(1);
		chk(remote_defect_report, 1'b0);
		chk(outgoing_defect_report, 1'b0);
		en <= 1'b1;
		for (int i = 0; i <= 16; i++) begin
			frames(1);
			e = (i < 16) && (pay[0] || i == 1);
			r = (i < 16) && pay[1];
			o = (i < 16) && pay[2];
			one_second <= (i == 0 || i == 16);
			err <= e;
			rei <= r;
			oei <= o;
			ne += e;
			nf += r;
			nof += o;
		end
		frames(1);
		chk(near_error_count, ne);
		chk(near_error_count, ne);
		chk(far_error_count, nf);
		chk(outgoing_far_error_count, nof);
		chk(near_defect_second, 1'b0);
		chk(far_defect_second, 1'b1);
		chk(outgoing_far_defect_second, 1'b1);
		chk(trail_degrade_action, 1'b1);
		chk(degrade_report, 1'b1);
		expected_trace <= trace ^ 128'h1;
		frames(1);
		chk(trace_mismatch_report, 1'b1);
		chk(trail_fail_action, 1'b1);
		chk(remote_defect_report, 1'b0);
		chk(degrade_report, 1'b0);
		mismatch_disable <= 1'b1;
		frames(1);
		chk(trace_mismatch_report, 1'b0);
		chk(trail_fail_action, 1'b0);
		mismatch_disable <= 1'b0;
		server_fail <= 1'b1;
		frames(1);
		chk(trace_mismatch_report, 1'b0);
		chk(server_fail_report, 1'b1);
		chk(trail_fail_action, tsf(1'b1, 1'b0, 1'b0, 1'b0));
		ssf_en <= 1'b0;
		frames(1);
		chk(server_fail_report, 1'b0);
		ssf_en <= 1'b1;
		termination_point_mode <= 1'b0;
		frames(1);
		chk(server_fail_report, 1'b0);
		termination_point_mode <= 1'b1;
		server_fail <= 1'b0;
		expected_trace <= trace;
		zero <= 1'b1;
		frames(6);
		chk(unequipped_report, 1'b1);
		chk(tandem_loss_report, 1'b0);
		chk(trail_fail_action, 1'b1);
		zero <= 1'b0;
		frames(4);
		chk(unequipped_report, 1'b1);
		frames(2);
		chk(unequipped_report, 1'b0);
		fas_bad <= 1'b1;
		frames(76);
		fas_bad <= 1'b0;
		frames(2);
		chk(tandem_loss_report, 1'b0);
		fas_bad <= 1'b1;
		frames(160);
		chk(tandem_loss_report, 1'b1);
		fas_bad <= 1'b0;
		frames(90);
		chk(tandem_loss_report, 1'b0);
		summarize();
	end
endmodule // tb_vc2_tandem_conn_monitor_sink
`default_nettype wire
